// >>> odt_zq_pkg.sv
package odt_zq_pkg;

  // clock figures
  localparam int CLK_PERIOD_PS     = 20000;

  // asynchronous termination delays, picoseconds as specified
  localparam int AONPD_MIN_PS      = 2000;
  localparam int AONPD_MAX_PS      = 8500;
  localparam int AOFPD_MIN_PS      = 2000;
  localparam int AOFPD_MAX_PS      = 8500;

  // least times round up, longest times round down, never below one cycle
  localparam int AONPD_MIN_CYC =
    (AONPD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS < 1 ? 1 :
    (AONPD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int AONPD_MAX_CYC =
    AONPD_MAX_PS / CLK_PERIOD_PS < 1 ? 1 : AONPD_MAX_PS / CLK_PERIOD_PS;
  localparam int AOFPD_MIN_CYC =
    (AOFPD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS < 1 ? 1 :
    (AOFPD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int AOFPD_MAX_CYC =
    AOFPD_MAX_PS / CLK_PERIOD_PS < 1 ? 1 : AOFPD_MAX_PS / CLK_PERIOD_PS;

  // latencies in clocks
  localparam int         CWL_CYC      = 8;
  localparam int         AL_CYC       = 0;
  localparam int         ODTL_SUB     = 2;
  localparam int         ANPD_SUB     = 1;
  localparam int         WL_CYC       = CWL_CYC + AL_CYC;
  localparam int         ODTL_CYC     = CWL_CYC + AL_CYC - ODTL_SUB;
  localparam int         ANPD_CYC     = WL_CYC - ANPD_SUB;
  localparam int         CPDED_CYC    = 1;
  localparam int         RFC_CYC      = 16;
  localparam int         XPDLL_CYC    = 24;

  // calibration windows in clocks (values above 4096 are top parameters)
  localparam int         ZQINIT_CYC   = 512;
  localparam int         ZQOPER_CYC   = 256;
  localparam int         ZQCS_CYC     = 64;

  localparam int         DLY_W        = 32;
  localparam int         CNT_W        = 16;
  localparam int         MR0_FREEZE_BIT = 12;
  localparam logic       MR0_FREEZE_VAL = 1'b0;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_REF, CMD_ZQCL, CMD_ZQCS, CMD_SRX, CMD_OTHER
  } cmd_t;

endpackage : odt_zq_pkg

// >>> odt_delay_line.sv
`timescale 1ns/1ps
`default_nettype none
// fixed-length shift of a single bit; tap 0 is the input itself
module odt_delay_line #(
  parameter int DEPTH = 32
) (
  input  wire logic             i_clk,
  input  wire logic             i_nrst,
  input  wire logic             i_ce,
  input  wire logic             i_d,
  output logic [DEPTH-1:0]      o_taps
);
  logic [DEPTH-2:0] sh_reg;
  logic [DEPTH-2:0] sh_next;

  assign sh_next = {sh_reg[DEPTH-3:0], i_d};
  assign o_taps  = {sh_reg, i_d};

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sh_reg <= '0;
    end else if (i_ce) begin
      sh_reg <= sh_next;
    end
  end
endmodule : odt_delay_line
`default_nettype wire

// >>> odt_zq_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module odt_zq_ctrl #(
  parameter int ZQINIT = odt_zq_pkg::ZQINIT_CYC,
  parameter int ZQOPER = odt_zq_pkg::ZQOPER_CYC,
  parameter int ZQCS   = odt_zq_pkg::ZQCS_CYC
) (
  input  wire logic        I_CLOCK,
  input  wire logic        I_NRST,
  input  wire logic        I_CE,
  input  wire logic        I_CKE,
  input  wire logic        I_ODT,
  input  wire logic [2:0]  I_CMD,
  input  wire logic [15:0] I_MR0,
  input  wire logic [7:0]  I_CAL_CODE,
  output logic             O_RTT_EN,
  output logic             O_RTT_FULL,
  output logic             O_ASYNC_MODE,
  output logic             O_TRANSITION,
  output logic             O_PD_ACTIVE,
  output logic             O_ZQ_BUSY,
  output logic             O_ZQ_CURRENT_EN,
  output logic [7:0]       O_IO_CODE
);
  localparam int DW = odt_zq_pkg::DLY_W;

  // cke and odt from the controller pass a three-stage synchroniser; commands do not
  logic [2:0] cke_sy_reg;
  logic [2:0] odt_sy_reg;
  logic       cke_reg;
  logic       odt_reg;
  logic       cke_next;
  logic       odt_next;

  assign cke_next = (cke_sy_reg[2] == cke_sy_reg[1]) ? cke_sy_reg[1] : cke_reg;
  assign odt_next = (odt_sy_reg[2] == odt_sy_reg[1]) ? odt_sy_reg[1] : odt_reg;

  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      cke_sy_reg <= 3'h7;
      odt_sy_reg <= 3'h0;
      cke_reg    <= 1'b1;
      odt_reg    <= 1'b0;
    end else if (I_CE) begin
      cke_sy_reg <= {cke_sy_reg[1:0], I_CKE};
      odt_sy_reg <= {odt_sy_reg[1:0], I_ODT};
      cke_reg    <= cke_next;
      odt_reg    <= odt_next;
    end
  end

  // odt history; tap n is odt as it stood n cycles ago
  logic [DW-1:0] odt_taps;
  odt_delay_line #(.DEPTH(DW)) u_odt_hist (
    .i_clk  (I_CLOCK),
    .i_nrst (I_NRST),
    .i_ce   (I_CE),
    .i_d    (odt_reg),
    .o_taps (odt_taps)
  );

  // power-down tracking and decoded commands
  odt_zq_pkg::cmd_t cmd;
  logic pd_reg;
  logic cke_fall;
  logic cke_rise;
  logic cmd_ref;
  logic cmd_zqcl;
  logic cmd_zqcs;
  logic freeze_sel;

  assign cmd        = odt_zq_pkg::cmd_t'(I_CMD);
  assign cmd_ref    = cke_reg && (cmd == odt_zq_pkg::CMD_REF);
  assign cmd_zqcl   = cke_reg && (cmd == odt_zq_pkg::CMD_ZQCL);
  assign cmd_zqcs   = cke_reg && (cmd == odt_zq_pkg::CMD_ZQCS);
  assign cke_fall   = pd_reg == 1'b0 && !cke_reg;
  assign cke_rise   = pd_reg && cke_reg;
  assign freeze_sel =
    I_MR0[odt_zq_pkg::MR0_FREEZE_BIT] == odt_zq_pkg::MR0_FREEZE_VAL;

  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      pd_reg <= 1'b0;
    end else if (I_CE) begin
      pd_reg <= !cke_reg;
    end
  end

  // the device only learns of cke after the fact; the window is counted
  // from the synchronised cke edge on (tCPDED or remaining tRFC on entry,
  // XPDLL on exit); odt events before the edge keep the bounds they got
  logic [15:0] rfc_cnt_reg;
  logic [15:0] rfc_cnt_next;
  logic [15:0] win_cnt_reg;
  logic [15:0] win_cnt_next;
  logic [15:0] ent_len;
  logic        rfc_busy;

  assign rfc_busy     = rfc_cnt_reg != 16'h0000;
  assign rfc_cnt_next = cmd_ref ? 16'(odt_zq_pkg::RFC_CYC) :
                        rfc_busy ? rfc_cnt_reg - 16'h0001 : rfc_cnt_reg;
  // end points of tCPDED and tRFC are inside the window
  assign ent_len = (rfc_cnt_reg > 16'(odt_zq_pkg::CPDED_CYC)) ?
                   rfc_cnt_reg : 16'(odt_zq_pkg::CPDED_CYC);
  // merged: a new edge only ever extends the remaining window
  assign win_cnt_next =
    (freeze_sel && cke_fall) ? ((ent_len > win_cnt_reg) ? ent_len :
                                win_cnt_reg) :
    (freeze_sel && cke_rise) ?
      ((16'(odt_zq_pkg::XPDLL_CYC) > win_cnt_reg) ?
       16'(odt_zq_pkg::XPDLL_CYC) : win_cnt_reg) :
    (win_cnt_reg != 16'h0000) ? win_cnt_reg - 16'h0001 : win_cnt_reg;

  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      rfc_cnt_reg <= 16'h0000;
      win_cnt_reg <= 16'h0000;
    end else if (I_CE) begin
      rfc_cnt_reg <= rfc_cnt_next;
      win_cnt_reg <= win_cnt_next;
    end
  end

  // window flag: counter running or a cke edge this cycle; there is no
  // pre-edge part, and async mode needs freeze, pd_reg and no window
  logic        async_mode;
  logic        in_window;

  assign async_mode = freeze_sel && pd_reg && !in_window;
  assign in_window  = win_cnt_reg != 16'h0000 || cke_fall || cke_rise;

  // odt change detection on the synchronised level
  logic odt_rise;
  logic odt_fall;
  assign odt_rise = odt_taps[0] && !odt_taps[1];
  assign odt_fall = !odt_taps[0] && odt_taps[1];

  // termination state: a pending change counts down to its start and full
  logic [7:0]  on_start_reg;
  logic [7:0]  on_full_reg;
  logic [7:0]  off_start_reg;
  logic [7:0]  off_full_reg;
  logic [7:0]  on_start_next;
  logic [7:0]  on_full_next;
  logic [7:0]  off_start_next;
  logic [7:0]  off_full_next;
  logic [7:0]  on_lo;
  logic [7:0]  on_hi;
  logic [7:0]  off_lo;
  logic [7:0]  off_hi;
  logic [7:0]  sync_dly;
  logic        rtt_en_reg;
  logic        rtt_full_reg;
  logic        rtt_en_next;
  logic        rtt_full_next;
  logic        win_or_edge;

  // sync response: internal odt delayed by CWL+AL-2
  assign sync_dly = 8'(odt_zq_pkg::ODTL_CYC);
  assign win_or_edge = in_window;

  // bounds per mode; async ignores AL, window takes the wider envelope
  assign on_lo  = win_or_edge ?
    ((8'(odt_zq_pkg::AONPD_MIN_CYC) < sync_dly) ?
     8'(odt_zq_pkg::AONPD_MIN_CYC) : sync_dly) :
    async_mode ? 8'(odt_zq_pkg::AONPD_MIN_CYC) : sync_dly;
  assign on_hi  = win_or_edge ?
    ((8'(odt_zq_pkg::AONPD_MAX_CYC) > sync_dly) ?
     8'(odt_zq_pkg::AONPD_MAX_CYC) : sync_dly) :
    async_mode ? 8'(odt_zq_pkg::AONPD_MAX_CYC) : sync_dly;
  assign off_lo = win_or_edge ?
    ((8'(odt_zq_pkg::AOFPD_MIN_CYC) < sync_dly) ?
     8'(odt_zq_pkg::AOFPD_MIN_CYC) : sync_dly) :
    async_mode ? 8'(odt_zq_pkg::AOFPD_MIN_CYC) : sync_dly;
  assign off_hi = win_or_edge ?
    ((8'(odt_zq_pkg::AOFPD_MAX_CYC) > sync_dly) ?
     8'(odt_zq_pkg::AOFPD_MAX_CYC) : sync_dly) :
    async_mode ? 8'(odt_zq_pkg::AOFPD_MAX_CYC) : sync_dly;

  // a new edge cancels the opposite pending change
  assign on_start_next  = odt_rise ? on_lo :
    (odt_fall ? 8'h00 : (on_start_reg != 8'h00 ? on_start_reg - 8'h01 :
                         8'h00));
  assign on_full_next   = odt_rise ? on_hi :
    (odt_fall ? 8'h00 : (on_full_reg != 8'h00 ? on_full_reg - 8'h01 :
                         8'h00));
  assign off_start_next = odt_fall ? off_lo :
    (odt_rise ? 8'h00 : (off_start_reg != 8'h00 ? off_start_reg - 8'h01 :
                         8'h00));
  assign off_full_next  = odt_fall ? off_hi :
    (odt_rise ? 8'h00 : (off_full_reg != 8'h00 ? off_full_reg - 8'h01 :
                         8'h00));

  // enabled from turn-on start through turn-off end (high impedance)
  assign rtt_en_next =
    (on_start_reg == 8'h01)  ? 1'b1 :
    (off_full_reg == 8'h01)  ? 1'b0 : rtt_en_reg;
  assign rtt_full_next =
    (on_full_reg == 8'h01)   ? 1'b1 :
    (off_start_reg == 8'h01) ? 1'b0 : rtt_full_reg;

  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      on_start_reg  <= 8'h00;
      on_full_reg   <= 8'h00;
      off_start_reg <= 8'h00;
      off_full_reg  <= 8'h00;
      rtt_en_reg    <= 1'b0;
      rtt_full_reg  <= 1'b0;
    end else if (I_CE) begin
      on_start_reg  <= on_start_next;
      on_full_reg   <= on_full_next;
      off_start_reg <= off_start_next;
      off_full_reg  <= off_full_next;
      rtt_en_reg    <= rtt_en_next;
      rtt_full_reg  <= rtt_full_next;
    end
  end

  // ZQ calibration engine
  typedef enum logic [1:0] {ZQ_IDLE, ZQ_CAL, ZQ_XFER} zq_state_t;
  zq_state_t    zq_state_reg;
  zq_state_t    zq_state_next;
  logic [15:0]  zq_cnt_reg;
  logic [15:0]  zq_cnt_next;
  logic         first_done_reg;
  logic         first_done_next;
  logic [7:0]   io_code_reg;
  logic [7:0]   io_code_next;
  logic [15:0]  zq_len;
  logic         zq_start;

  // only explicit commands start calibration; self-refresh exit does not
  assign zq_start = (cmd_zqcl || cmd_zqcs) && zq_state_reg == ZQ_IDLE;
  assign zq_len   = cmd_zqcs ? 16'(ZQCS - 1) :
                    (!first_done_reg ? 16'(ZQINIT - 1) :
                     16'(ZQOPER - 1));

  always_comb begin
    zq_state_next   = zq_state_reg;
    zq_cnt_next     = zq_cnt_reg;
    first_done_next = first_done_reg;
    io_code_next    = io_code_reg;
    unique case (zq_state_reg)
      ZQ_IDLE: begin
        if (zq_start) begin
          zq_state_next = ZQ_CAL;
          zq_cnt_next   = zq_len;
          if (cmd_zqcl) begin
            first_done_next = 1'b1;
          end
        end
      end
      ZQ_CAL: begin
        if (zq_cnt_reg <= 16'h0001) begin
          zq_state_next = ZQ_XFER;
        end else begin
          zq_cnt_next = zq_cnt_reg - 16'h0001;
        end
      end
      ZQ_XFER: begin
        // transfer lands inside the window; drivers and termination update
        io_code_next  = I_CAL_CODE;
        zq_state_next = ZQ_IDLE;
        zq_cnt_next   = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      zq_state_reg   <= ZQ_IDLE;
      zq_cnt_reg     <= 16'h0000;
      first_done_reg <= 1'b0;
      io_code_reg    <= 8'h00;
    end else if (I_CE) begin
      zq_state_reg   <= zq_state_next;
      zq_cnt_reg     <= zq_cnt_next;
      first_done_reg <= first_done_next;
      io_code_reg    <= io_code_next;
    end
  end

  assign O_RTT_EN        = rtt_en_reg;
  assign O_RTT_FULL      = rtt_full_reg;
  assign O_ASYNC_MODE    = async_mode;
  assign O_TRANSITION    = in_window;
  assign O_PD_ACTIVE     = pd_reg;
  assign O_ZQ_BUSY       = zq_state_reg != ZQ_IDLE;
  // current path only drawn while measuring
  assign O_ZQ_CURRENT_EN = zq_state_reg == ZQ_CAL;
  assign O_IO_CODE       = io_code_reg;

endmodule : odt_zq_ctrl
`default_nettype wire

// >>> odt_zq_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module odt_zq_asserts #(
  parameter int ZQINIT = 8,
  parameter int ZQOPER = 6,
  parameter int ZQCS   = 4
) (
  input wire logic        I_CLOCK,
  input wire logic        I_NRST,
  input wire logic        I_CE,
  input wire logic        I_CKE,
  input wire logic        I_ODT,
  input wire logic [2:0]  I_CMD,
  input wire logic [15:0] I_MR0,
  input wire logic [7:0]  I_CAL_CODE,
  input wire logic        O_RTT_EN,
  input wire logic        O_RTT_FULL,
  input wire logic        O_ASYNC_MODE,
  input wire logic        O_TRANSITION,
  input wire logic        O_PD_ACTIVE,
  input wire logic        O_ZQ_BUSY,
  input wire logic        O_ZQ_CURRENT_EN,
  input wire logic [7:0]  O_IO_CODE
);
  // length of the running calibration window, frozen with the block
  logic [15:0] busy_cnt_reg;
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      busy_cnt_reg <= 16'h0000;
    end else if (I_CE) begin
      busy_cnt_reg <= O_ZQ_BUSY ? busy_cnt_reg + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_NRST);
  a_async_mode_cause: assert property (
    O_ASYNC_MODE |-> O_PD_ACTIVE && !I_MR0[12])
    else $error("async timing outside frozen power-down");
  a_full_needs_en: assert property (
    O_RTT_FULL |-> O_RTT_EN) else $error("full without enable");
  a_sync_rise_late: assert property (
    !O_PD_ACTIVE && !O_TRANSITION && $rose(O_RTT_EN) |-> $past(I_ODT, 6))
    else $error("sync turn-on too early");
  a_current_in_cal: assert property (
    O_ZQ_CURRENT_EN |-> O_ZQ_BUSY) else $error("current path left on");
  a_code_held: assert property (
    !O_ZQ_BUSY && !$past(O_ZQ_BUSY) |-> $stable(O_IO_CODE))
    else $error("io code moved while idle");
  a_code_loaded: assert property (
    $fell(O_ZQ_BUSY) |-> O_IO_CODE == $past(I_CAL_CODE))
    else $error("io code not loaded");
  a_zq_length: assert property (
    $fell(O_ZQ_BUSY) |->
      busy_cnt_reg inside {ZQCS, ZQOPER, ZQINIT})
    else $error("calibration window length wrong");
  a_no_self_cal: assert property (
    !O_ZQ_BUSY && I_CMD != odt_zq_pkg::CMD_ZQCL &&
    I_CMD != odt_zq_pkg::CMD_ZQCS |=> !O_ZQ_BUSY)
    else $error("calibration without command");
  c_zq_done: cover property ($fell(O_ZQ_BUSY));
  c_async_on: cover property (O_ASYNC_MODE && O_RTT_FULL);
  c_window: cover property ($rose(O_TRANSITION));
endmodule : odt_zq_asserts
bind odt_zq_ctrl odt_zq_asserts #(
  .ZQINIT(ZQINIT), .ZQOPER(ZQOPER), .ZQCS(ZQCS)
) odt_zq_asserts_inst (
  .I_CLOCK(I_CLOCK), .I_NRST(I_NRST), .I_CE(I_CE), .I_CKE(I_CKE),
  .I_ODT(I_ODT), .I_CMD(I_CMD), .I_MR0(I_MR0), .I_CAL_CODE(I_CAL_CODE),
  .O_RTT_EN(O_RTT_EN), .O_RTT_FULL(O_RTT_FULL),
  .O_ASYNC_MODE(O_ASYNC_MODE), .O_TRANSITION(O_TRANSITION),
  .O_PD_ACTIVE(O_PD_ACTIVE), .O_ZQ_BUSY(O_ZQ_BUSY),
  .O_ZQ_CURRENT_EN(O_ZQ_CURRENT_EN), .O_IO_CODE(O_IO_CODE)
);
`default_nettype wire

// >>> mc_model.sv
`timescale 1ns/1ps
`default_nettype none
// single rank, so calibration windows of ranks never overlap
module mc_model #(
  parameter int ZQINIT = 8,
  parameter int ZQOPER = 6,
  parameter int ZQCS   = 4,
  parameter int RP     = 2,
  parameter int XS     = 4
) (
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic [2:0] i_cmd,
  input  wire logic       i_cke,
  input  wire logic       i_odt,
  output logic [2:0]      o_cmd,
  output logic            o_cke,
  output logic            o_odt
);
  logic [15:0] quiet_reg;
  logic        first_reg;
  wire  logic  hold = quiet_reg != 16'h0000;
  // requests that arrive during a quiet time are dropped, not queued
  assign o_cmd = hold ? odt_zq_pkg::CMD_NOP : i_cmd;
  assign o_cke = i_cke;
  assign o_odt = i_odt;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      quiet_reg <= 16'h0000;
      first_reg <= 1'b1;
    end else if (hold) begin
      quiet_reg <= quiet_reg - 16'h0001;
    end else begin
      case (i_cmd)
        odt_zq_pkg::CMD_ZQCL: begin
          quiet_reg <= first_reg ? 16'(ZQINIT) : 16'(ZQOPER);
          first_reg <= 1'b0;
        end
        odt_zq_pkg::CMD_ZQCS: quiet_reg <= 16'(ZQCS);
        odt_zq_pkg::CMD_SRX:  quiet_reg <= 16'(XS);
        odt_zq_pkg::CMD_NOP:  quiet_reg <= 16'h0000;
        default:              quiet_reg <= 16'(RP);
      endcase
    end
  end
endmodule : mc_model
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int ZQI  = 8;
  localparam int ZQO  = 6;
  localparam int ZQS  = 4;
  localparam int ODTL = odt_zq_pkg::ODTL_CYC;
  localparam int XPD  = odt_zq_pkg::XPDLL_CYC;
  logic        I_CLOCK    = 1'b0;
  logic        I_NRST     = 1'b0;
  logic        I_CE       = 1'b1;
  logic [15:0] I_MR0      = 16'h1000;
  logic [7:0]  I_CAL_CODE = 8'h5A;
  logic [2:0]  cmd_req    = 3'h0;
  logic        cke_req    = 1'b1;
  logic        odt_req    = 1'b0;
  logic [2:0]  I_CMD;
  logic        I_CKE, I_ODT, O_RTT_EN, O_RTT_FULL, O_ASYNC_MODE;
  logic        O_TRANSITION, O_PD_ACTIVE, O_ZQ_BUSY, O_ZQ_CURRENT_EN;
  logic [7:0]  O_IO_CODE;
  int          errors     = 0;
  int          tests_run  = 0;
  always #10 I_CLOCK = ~I_CLOCK;
  mc_model #(.ZQINIT(ZQI), .ZQOPER(ZQO), .ZQCS(ZQS)) mc_model_inst (
    .i_clk(I_CLOCK), .i_nrst(I_NRST), .i_cmd(cmd_req), .i_cke(cke_req),
    .i_odt(odt_req), .o_cmd(I_CMD), .o_cke(I_CKE), .o_odt(I_ODT));
  odt_zq_ctrl #(.ZQINIT(ZQI), .ZQOPER(ZQO), .ZQCS(ZQS)) odt_zq_ctrl_inst (
    .I_CLOCK(I_CLOCK), .I_NRST(I_NRST), .I_CE(I_CE), .I_CKE(I_CKE),
    .I_ODT(I_ODT), .I_CMD(I_CMD), .I_MR0(I_MR0), .I_CAL_CODE(I_CAL_CODE),
    .O_RTT_EN(O_RTT_EN), .O_RTT_FULL(O_RTT_FULL),
    .O_ASYNC_MODE(O_ASYNC_MODE), .O_TRANSITION(O_TRANSITION),
    .O_PD_ACTIVE(O_PD_ACTIVE), .O_ZQ_BUSY(O_ZQ_BUSY),
    .O_ZQ_CURRENT_EN(O_ZQ_CURRENT_EN), .O_IO_CODE(O_IO_CODE));
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic tick(input int n);
    repeat (n) @(posedge I_CLOCK);
    #1;
  endtask : tick
  task automatic check(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : check
  function automatic logic pick(input int sel);
    return sel == 0 ? O_RTT_EN : sel == 1 ? O_ZQ_BUSY :
           sel == 2 ? O_TRANSITION : O_RTT_FULL;
  endfunction : pick
  // counts cycles while the chosen output keeps level v
  task automatic hold_for(input int sel, input logic v, output int n);
    n = 0;
    while (pick(sel) === v && n < 1000) begin
      tick(1);
      n++;
    end
    if (n >= 1000) begin
      $display("[ERR] %0t wait limit", $time);
      errors++;
      wrap_up();
    end
  endtask : hold_for
  task automatic issue(input odt_zq_pkg::cmd_t c);
    cmd_req = c;
    tick(1);
    cmd_req = 3'h0;
  endtask : issue
  task automatic t_zq;
    int n;
    issue(odt_zq_pkg::CMD_ZQCL);
    check(O_ZQ_BUSY === 1'b1 && O_ZQ_CURRENT_EN === 1'b1, "zq start");
    hold_for(1, 1'b1, n);
    check(n == ZQI, "first long length");
    check(O_IO_CODE === 8'h5A && !O_ZQ_CURRENT_EN, "code or current");
    I_CAL_CODE = 8'hC3;
    issue(odt_zq_pkg::CMD_ZQCL);
    hold_for(1, 1'b1, n);
    check(n == ZQO && O_IO_CODE === 8'hC3, "later long");
    I_CAL_CODE = 8'h3C;
    issue(odt_zq_pkg::CMD_ZQCS);
    hold_for(1, 1'b1, n);
    check(n == ZQS && O_IO_CODE === 8'h3C, "short cal");
    issue(odt_zq_pkg::CMD_SRX);
    tick(4);
    check(O_ZQ_BUSY === 1'b0 && O_IO_CODE === 8'h3C, "self cal");
    $display("test zq done");
  endtask : t_zq
  task automatic t_odt(input logic async, input int lo, input int hi);
    int n;
    I_MR0 = async ? 16'h0000 : 16'h1000;
    cke_req = !async;
    tick(12);
    check(O_ASYNC_MODE === async && O_TRANSITION === 1'b0, "mode");
    // deterministic timing wanted here, so odt only moves outside windows
    check(O_TRANSITION === 1'b0, "odt toggled in window");
    odt_req = 1'b1;
    hold_for(0, 1'b0, n);
    check(n >= lo && n <= hi, "turn-on delay");
    hold_for(3, 1'b0, n);
    check(n <= 1, "full by max");
    odt_req = 1'b0;
    hold_for(3, 1'b1, n);
    check(n >= lo && n <= hi, "turn-off delay");
    hold_for(0, 1'b1, n);
    check(n <= 1, "off by max");
    cke_req = 1'b1;
    tick(40);
    $display("test odt done");
  endtask : t_odt
  task automatic t_freeze_off;
    I_MR0 = 16'h1000;
    cke_req = 1'b0;
    tick(12);
    check(O_PD_ACTIVE === 1'b1 && O_ASYNC_MODE === 1'b0, "dll kept");
    cke_req = 1'b1;
    tick(40);
    $display("test freeze off done");
  endtask : t_freeze_off
  task automatic t_windows;
    int n, nw, nr;
    I_MR0 = 16'h0000;
    cke_req = 1'b0;
    hold_for(2, 1'b0, n);
    hold_for(2, 1'b1, nw);
    check(n <= 6 && nw >= 1 && nw <= 3, "entry window");
    tick(10);
    cke_req = 1'b1;
    hold_for(2, 1'b0, n);
    odt_req = 1'b1;
    hold_for(0, 1'b0, n);
    check(n >= 1 && n <= ODTL + 5, "on in window");
    odt_req = 1'b0;
    hold_for(0, 1'b1, n);
    check(n >= 1 && n <= ODTL + 5, "off in window");
    tick(40);
    cke_req = 1'b0;
    tick(12);
    cke_req = 1'b1;
    hold_for(2, 1'b0, n);
    hold_for(2, 1'b1, n);
    check(n >= XPD && n <= XPD + 2, "exit window");
    tick(10);
    issue(odt_zq_pkg::CMD_REF);
    cke_req = 1'b0;
    hold_for(2, 1'b0, n);
    hold_for(2, 1'b1, nr);
    check(nr > nw + 4 && nr <= odt_zq_pkg::RFC_CYC + 1, "refresh");
    cke_req = 1'b1;
    tick(40);
    cke_req = 1'b0;
    tick(2);
    cke_req = 1'b1;
    hold_for(2, 1'b0, n);
    hold_for(2, 1'b1, n);
    check(n >= XPD, "merged windows");
    tick(40);
    $display("test windows done");
  endtask : t_windows
  initial begin
    tick(8);
    I_NRST = 1'b1;
    tick(4);
    t_zq();
    t_odt(1'b0, ODTL + 1, ODTL + 5);
    t_odt(1'b1, odt_zq_pkg::AONPD_MIN_CYC + 1, odt_zq_pkg::AONPD_MAX_CYC + 5);
    t_freeze_off();
    t_windows();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
